// >>> i2csl_top.v
// Two-wire bus slave giving access to identity, status and event registers
// Assumes scl/sda pins come in asynchronously; status inputs are synchronous
`include "i2csl_consts.vh"

module i2csl_top #(
  parameter [15:0] IDENT_CODE = 16'h1234_ // Arbitrary identity value
)(
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_addr_select_low,
  input wire i_addr_select_high,
  input wire i_power_on_event,
  input wire [15:0] i_live_conditions,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_soft_reset,
  output reg [7:0] o_reg_pointer
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ADDR_ACK = 3'd2;
  localparam [2:0] ST_WR = 3'd3;
  localparam [2:0] ST_WR_ACK = 3'd4;
  localparam [2:0] ST_RD = 3'd5;
  localparam [2:0] ST_RD_ACK = 3'd6;
  localparam [2:0] ST_WAIT_STOP = 3'd7;

  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg rw_read;
  reg ptr_loaded;
  reg hi_phase;
  reg [7:0] hi_byte;
  reg [15:0] live_q;
  reg [15:0] live_prev;
  reg [15:0] event_flags;
  reg [15:0] rd_word;
  reg event_read;
  reg [1:0] sel_sync0;
  reg [1:0] sel_sync1;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
  wire [6:0] own_addr = {`I2CSL_ADDR_BASE, sel_sync1[1], sel_sync1[0]};

  // Register read mux
  function [15:0] read_reg;
    input [7:0] ptr;
    input [15:0] live;
    input [15:0] flags;
    begin
      if (ptr == `I2CSL_PTR_IDENT)
        read_reg = IDENT_CODE;
      else if (ptr == `I2CSL_PTR_LIVE)
        read_reg = live & `I2CSL_LIVE_MASK;
      else if (ptr == `I2CSL_PTR_EVENT)
        read_reg = flags & `I2CSL_LIVE_MASK;
      else
        read_reg = 16'h0000;
    end
  endfunction

  // Word the pointer selects right now
  wire [15:0] rd_next = read_reg(o_reg_pointer, live_q, event_flags);

  // Pin synchronisers
  always @(posedge i_clock)
  begin
    scl_m <= i_scl;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= i_sda;
    sda_s <= sda_m;
    sda_d <= sda_s;
    sel_sync0 <= {i_addr_select_high, i_addr_select_low};
    sel_sync1 <= sel_sync0;
  end

  // Event flags: set wins over clear-on-read
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      live_q <= `I2CSL_RST_FLAGS;
      live_prev <= `I2CSL_RST_FLAGS;
      event_flags <= `I2CSL_RST_FLAGS;
    end
    else
    begin
      live_q <= i_live_conditions & `I2CSL_LIVE_MASK;
      live_prev <= live_q;
      event_flags <= ((event_read ? 16'h0000 : event_flags)
        | (live_q ^ live_prev)
        | ({15'h0000, i_power_on_event} << `I2CSL_UV_BIT))
        & `I2CSL_LIVE_MASK;
    end
  end

  // Serial protocol engine
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw_read <= 1'b0;
      ptr_loaded <= 1'b0;
      hi_phase <= 1'b1;
      hi_byte <= 8'h00;
      rd_word <= 16'h0000;
      event_read <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_soft_reset <= 1'b0;
      o_reg_pointer <= `I2CSL_RST_PTR;
    end
    else
    begin
      event_read <= 1'b0;
      o_soft_reset <= 1'b0;
      if (start_cond)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (scl_s && scl_d && (sda_s != sda_d) && state != ST_IDLE)
      begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WR:
          begin
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `I2CSL_BITS_PER_BYTE)
            begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                if (shift[7:1] == own_addr)
                begin
                  rw_read <= shift[0];
                  ptr_loaded <= shift[0];
                  hi_phase <= 1'b1;
                  o_sda_out <= 1'b0;
                  o_sda_oe <= 1'b1;
                  state <= ST_ADDR_ACK;
                end
                else
                  state <= ST_IDLE;
              end
              else
              begin
                o_sda_out <= 1'b0;
                o_sda_oe <= 1'b1;
                state <= ST_WR_ACK;
                if (!ptr_loaded)
                begin
                  o_reg_pointer <= shift;
                  ptr_loaded <= 1'b1;
                end
                else if (hi_phase)
                begin
                  hi_byte <= shift;
                  hi_phase <= 1'b0;
                end
                else
                begin
                  hi_phase <= 1'b1;
                  if (o_reg_pointer == `I2CSL_PTR_IDENT &&
                      {hi_byte, shift} == `I2CSL_SOFT_RST_KEY)
                    o_soft_reset <= 1'b1;
                  o_reg_pointer <= o_reg_pointer + 8'h01;
                end
              end
            end
          end
          ST_ADDR_ACK, ST_WR_ACK:
          begin
            if (scl_fall)
            begin
              if (rw_read)
              begin
                rd_word <= rd_next;
                o_sda_out <= 1'b0;
                o_sda_oe <= ~rd_next[15];
                bit_cnt <= 4'h1;
                state <= ST_RD;
              end
              else
              begin
                o_sda_oe <= 1'b0;
                state <= ST_WR;
              end
            end
          end
          ST_RD:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == `I2CSL_BITS_PER_BYTE)
              begin
                o_sda_oe <= 1'b0;
                bit_cnt <= 4'h0;
                state <= ST_RD_ACK;
              end
              else
              begin
                o_sda_oe <= ~(hi_phase ? rd_word[15 - bit_cnt]
                  : rd_word[7 - bit_cnt]);
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RD_ACK:
          begin
            if (scl_rise)
            begin
              if (!hi_phase && o_reg_pointer == `I2CSL_PTR_EVENT)
                event_read <= 1'b1;
              if (sda_s)
                state <= ST_WAIT_STOP;
              else if (hi_phase)
                hi_phase <= 1'b0;
              else
              begin
                hi_phase <= 1'b1;
                o_reg_pointer <= o_reg_pointer + 8'h01;
              end
            end
            else if (scl_fall)
            begin
              bit_cnt <= 4'h1;
              state <= ST_RD;
              if (hi_phase)
              begin
                rd_word <= rd_next;
                o_sda_oe <= ~rd_next[15];
              end
              else
                o_sda_oe <= ~rd_word[7];
            end
          end
          default:
            o_sda_oe <= 1'b0;
        endcase
      end
    end
  end

endmodule // i2csl_top

// >>> i2csl_consts.vh
// Constants for the two-wire register slave
// Assumes inclusion by i2csl_top.v only
`ifndef I2CSL_CONSTS_VH
`define I2CSL_CONSTS_VH
`define I2CSL_ADDR_BASE 5'b0_1101
`define I2CSL_PTR_IDENT 8'h00
`define I2CSL_PTR_LIVE 8'h01
`define I2CSL_PTR_EVENT 8'h02
`define I2CSL_SOFT_RST_KEY 16'h55aa
`define I2CSL_LIVE_MASK 16'h6fff
`define I2CSL_UV_BIT 14
`define I2CSL_OT_BIT 1
`define I2CSL_RST_PTR 8'h00
`define I2CSL_RST_FLAGS 16'h0000
`define I2CSL_BITS_PER_BYTE 4'h8
`endif

// >>> i2csl_checker.sv
// Port-level assertions for the two-wire register slave
// Bound to i2csl_top; one clock domain
module i2csl_checker (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  input wire i_addr_select_low,
  input wire i_addr_select_high,
  input wire i_power_on_event,
  input wire [15:0] i_live_conditions,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_soft_reset,
  input wire [7:0] o_reg_pointer
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  reset_idle_a: assert property ($fell(i_sys_rst) |->
    !o_sda_oe && !o_soft_reset && o_reg_pointer == 8'h00)
    else $error("not idle after reset");
  drive_low_a: assert property (o_sda_oe |-> !o_sda_out)
    else $error("line driven high");
  oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("drive changed with clock high");
  bit_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
    else $error("driven bit too short");
  stop_free_a: assert property (i_scl && $rose(i_sda) |-> !o_sda_oe)
    else $error("line driven at stop");
  start_free_a: assert property (i_scl && $fell(i_sda) |-> !o_sda_oe)
    else $error("line driven at start");
  soft_pulse_a: assert property (o_soft_reset |->
    !i_scl ##1 !o_soft_reset) else $error("soft reset pulse bad");
  ptr_quiet_a: assert property ($changed(o_reg_pointer) |=>
    $stable(o_reg_pointer) [*8]) else $error("pointer moved twice");
endmodule // i2csl_checker

bind i2csl_top i2csl_checker chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_scl(i_scl), .i_sda(i_sda), .i_addr_select_low(i_addr_select_low),
  .i_addr_select_high(i_addr_select_high),
  .i_power_on_event(i_power_on_event), .i_live_conditions(i_live_conditions),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_soft_reset(o_soft_reset),
  .o_reg_pointer(o_reg_pointer));

// >>> i2csl_master.sv
// Behavioural bus master, clock period 16 system clocks
// Assumes i_line is the wired level of the data line
module i2csl_master (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_scl,
  output logic o_sda,
  output logic [7:0] o_rx,
  output logic o_got
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_scl, o_sda, o_rx, o_got} = {2'b11, 8'h00, 1'b0};
  task automatic q();
    repeat (4) @(negedge i_clock);
  endtask
  task automatic cond(input logic a, input logic b);
    q();
    o_sda = a;
    q();
    o_scl = 1'b1;
    q();
    o_sda = b;
    q();
  endtask
  task automatic start();
    cond(1'b1, 1'b0);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    cond(1'b0, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ak_in,
    input logic rd, output logic ak);
    logic [8:0] s;
    logic [8:0] r;
    s = {tx, ak_in};
    for (int i = 8; i >= 0; i--)
    begin
      q();
      o_sda = s[i];
      q();
      o_scl = 1'b1;
      q();
      q();
      r[i] = i_line;
      o_scl = 1'b0;
    end
    o_rx = r[8:1];
    ak = r[0];
    o_got = rd;
    @(negedge i_clock);
    o_got = 1'b0;
  endtask
endmodule // i2csl_master

// >>> i2csl_top_tb.sv
// Self-checking bench for the two-wire register slave
// Pins are driven by the master model at falling clock edges
module i2csl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] IDC = 16'h3c5a; // Arbitrary identity value
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pwr = 1'b0;
  logic [1:0] asel = 2'b00;
  logic [15:0] live = 16'h0000;
  logic [15:0] lv;
  logic ak;
  wire scl, msda, so, oe, srst, got;
  wire [7:0] ptr, rx;
  wire line = msda & (oe ? so : 1'b1);
  int n_mismatch = 0;
  int checks_done = 0;
  int n_srst = 0;
  logic [7:0] exp_q[$];
  initial forever #5 clock = ~clock;
  i2csl_top #(.IDENT_CODE(IDC)) DUT (.i_clock(clock), .i_sys_rst(rst),
    .i_scl(scl), .i_sda(line), .i_addr_select_low(asel[0]),
    .i_addr_select_high(asel[1]), .i_power_on_event(pwr),
    .i_live_conditions(live), .o_sda_out(so), .o_sda_oe(oe),
    .o_soft_reset(srst), .o_reg_pointer(ptr));
  i2csl_master m (.i_clock(clock), .i_line(line), .o_scl(scl),
    .o_sda(msda), .o_rx(rx), .o_got(got));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic [7:0] b, input logic nak);
    m.xfer(b, 1'b1, 1'b0, ak);
    check("ack", {15'h0000, ak}, {15'h0000, nak});
  endtask
  task automatic exp16(input logic [15:0] w);
    exp_q.push_back(w[15:8]);
    exp_q.push_back(w[7:0]);
  endtask
  task automatic setp(input logic [7:0] p);
    m.start();
    wb({5'b01101, asel, 1'b0}, 1'b0);
    wb(p, 1'b0);
  endtask
  task automatic wr(input logic [7:0] p, input logic [31:0] d);
    setp(p);
    for (int i = 3; i >= 0; i--)
      wb(d[8*i+:8], 1'b0);
    m.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    setp(p);
    m.start();
    wb({5'b01101, asel, 1'b1}, 1'b0);
    for (int i = 2 * n - 1; i >= 0; i--)
      m.xfer(8'hff, i == 0, 1'b1, ak);
    m.stop();
  endtask
  always @(posedge got)
  begin
    if (exp_q.size() == 0)
      check("extra read", 16'h0001, 16'h0000);
    else
      check("read", {8'h00, rx}, {8'h00, exp_q.pop_front()});
  end
  always @(posedge clock)
    if (srst === 1'b1)
      n_srst++;
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    lv = $urandom(32'he7f6);
    asel = lv[1:0];
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    wr(8'h00, 32'h55aa_ffff);
    check("soft resets", n_srst[15:0], 16'h0001);
    check("pointer", {8'h00, ptr}, 16'h0002);
    exp16(IDC);
    exp16(16'h0000);
    rd(8'h00, 2);
    check("pointer", {8'h00, ptr}, 16'h0001);
    pwr = 1'b1;
    @(negedge clock);
    pwr = 1'b0;
    lv = $urandom;
    live = lv;
    exp16(lv & 16'h6fff);
    exp16((lv & 16'h6fff) | 16'h4000);
    exp16(16'h0000);
    rd(8'h01, 3);
    exp16(16'h0000);
    rd(8'h02, 1);
    pwr = 1'b1;
    @(negedge clock);
    pwr = 1'b0;
    exp16(16'h4000);
    exp16(16'h0000);
    rd(8'h02, 1);
    rd(8'h02, 1);
    wr(8'h01, 32'h55aa_55aa);
    check("soft resets", n_srst[15:0], 16'h0001);
    check("pointer", {8'h00, ptr}, 16'h0003);
    m.start();
    wb({5'b01101, ~asel, 1'b0}, 1'b1);
    m.stop();
    check("reads left", 16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule // i2csl_top_tb
